// >>> design/ptp_cfg_pkg.sv
// shared constants for the status-frame and receive-timestamp filter block
// assumes a 32-bit APB slave in front of 16-bit configuration registers
package ptp_cfg_pkg;

	// --------------------------------------------------------------------
	// register indices (byte address is four times the index)
	// --------------------------------------------------------------------
	localparam logic [7:0] STATUS_FRAME_CONFIG_IDX      = 8'h18;
	localparam logic [7:0] RECEIVE_TIMESTAMP_CONFIG_IDX = 8'h19;
	localparam logic [7:0] RECEIVE_DOMAIN_CONFIG_IDX    = 8'h1C;
	localparam logic [7:0] CUSTOM_IP_DATA_IDX           = 8'h1B;
	localparam logic [7:0] MATCH_COUNT_IDX              = 8'h20;

	// --------------------------------------------------------------------
	// status frame configuration fields
	// --------------------------------------------------------------------
	localparam int SRC_SEL_LSB   = 11;
	localparam int MIN_PRE_LSB   = 8;
	localparam int BYTE_ORDER_B  = 7;
	localparam int IP_TYPE_B     = 6;
	localparam int READBACK_B    = 5;
	localparam int ERR_DELIV_B   = 4;
	localparam int TX_STAMP_B    = 3;
	localparam int RX_STAMP_B    = 2;
	localparam int TRIGGER_B     = 1;
	localparam int EVENT_B       = 0;
	localparam logic [15:0] STATUS_FRAME_WMASK = 16'h1FFF;

	// --------------------------------------------------------------------
	// receive timestamp configuration fields
	// --------------------------------------------------------------------
	localparam int DOMAIN_EN_B   = 15;
	localparam int ALT_SKIP_B    = 14;
	localparam int IP_HALF_B     = 13;
	localparam int CUSTOM_IP_B   = 12;
	localparam int SLAVE_ONLY_B  = 11;
	localparam int STD_IP_LSB    = 8;
	localparam int LAYER2_B      = 7;
	localparam int V6_B          = 6;
	localparam int V4_B          = 5;
	localparam int VERSION_LSB   = 1;
	localparam int CAPTURE_B     = 0;

	// --------------------------------------------------------------------
	// reset values and fixed addresses
	// --------------------------------------------------------------------
	localparam logic [15:0] CONFIG_RESET   = 16'h0000;
	localparam logic [31:0] CUSTOM_IP_RESET = 32'h0000_0000;
	localparam logic [31:0] STD_ADDR_A     = 32'hE000_0181;
	localparam logic [31:0] STD_ADDR_B_LO  = 32'hE000_0182;
	localparam logic [31:0] STD_ADDR_B_HI  = 32'hE000_0184;
	localparam logic [31:0] STD_ADDR_C     = 32'hE000_006B;
	localparam logic [7:0]  SLAVE_SKIP_CTRL = 8'h01;

	// --------------------------------------------------------------------
	// encodings
	// --------------------------------------------------------------------
	typedef enum logic [1:0] {
		ENCAP_LAYER2,
		ENCAP_V4,
		ENCAP_V6,
		ENCAP_OTHER
	} encap_e;

endpackage

// >>> design/ptp_rx_filter_status_frame.sv
// configuration registers for status frames and receive stamp filtering
// assumes an apb master on core_clk and a parser giving one strobe per message
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module ptp_rx_filter_status_frame #(
	parameter logic [47:0] VENDOR_ADDR_A = 48'h02_00_00_00_00_01, // arbitrary value
	parameter logic [47:0] VENDOR_ADDR_B = 48'h02_00_00_00_00_02, // arbitrary value
	parameter logic [47:0] MULTICAST_DEST = 48'h01_1B_19_00_00_00
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	// parsed receive message
	input  wire logic                  msg_valid,
	input  wire ptp_cfg_pkg::encap_e   msg_encap,
	input  wire logic [3:0]            msg_version,
	input  wire logic [7:0]            msg_domain,
	input  wire logic                  msg_alt_master,
	input  wire logic [7:0]            msg_control,
	input  wire logic [31:0]           msg_dest_ip,
	// status frame pending events
	input  wire logic                  tx_stamp_ready,
	input  wire logic                  rx_stamp_ready,
	input  wire logic                  trigger_ready,
	input  wire logic                  event_ready,
	input  wire logic                  readback_ready,
	input  wire logic                  error_ready,
	// status frame builder controls
	output logic [47:0]                frame_source_addr,
	output logic [2:0]                 min_preamble,
	output logic                       status_byte_order,
	output logic                       status_frame_ip_type,
	output logic                       frame_request,
	output logic [5:0]                 frame_content,
	// receive stamp decision
	output logic                       rx_stamp_pulse,
	output logic                       rx_reject_pulse
);

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [15:0] status_cfg_reg;
	logic [15:0] rx_cfg_reg;
	logic [7:0]  domain_reg;
	logic [31:0] custom_ip_reg;
	logic [15:0] match_count_reg;
	logic        stamp_int;
	logic        reject_int;

	logic        wr_en;
	logic        rd_en;
	logic [9:0]  word_idx;
	logic        addr_ok;
	logic [15:0] wdata16;
	logic [1:0]  src_sel;
	logic [5:0]  content_now;

	assign word_idx = paddr[11:2];
	assign wdata16  = pwdata[15:0];
	assign wr_en    = psel && penable && pwrite;
	assign rd_en    = psel && !penable && !pwrite; // fetch in setup, stands with pready
	assign src_sel  = status_cfg_reg[ptp_cfg_pkg::SRC_SEL_LSB +: 2];

	// decode of one register word index, used by read and write paths
	function automatic logic is_reg(input logic [9:0] idx, input logic [7:0] which);
		is_reg = (idx == {2'h0, which});
	endfunction

	assign addr_ok = is_reg(word_idx, ptp_cfg_pkg::STATUS_FRAME_CONFIG_IDX)
		|| is_reg(word_idx, ptp_cfg_pkg::RECEIVE_TIMESTAMP_CONFIG_IDX)
		|| is_reg(word_idx, ptp_cfg_pkg::RECEIVE_DOMAIN_CONFIG_IDX)
		|| is_reg(word_idx, ptp_cfg_pkg::CUSTOM_IP_DATA_IDX)
		|| is_reg(word_idx, ptp_cfg_pkg::MATCH_COUNT_IDX);

	// ------------------------------------------------------------------
	// apb handshake: zero wait states
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
		end
	end

	// ------------------------------------------------------------------
	// status frame configuration
	// ------------------------------------------------------------------
	// only the low two byte lanes hold register bits
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_cfg_reg <= ptp_cfg_pkg::CONFIG_RESET;
		end else if (wr_en && pready
			&& is_reg(word_idx, ptp_cfg_pkg::STATUS_FRAME_CONFIG_IDX)) begin
			if (pstrb[0]) begin
				status_cfg_reg[7:0] <= wdata16[7:0];
			end
			if (pstrb[1]) begin
				status_cfg_reg[15:8] <= wdata16[15:8] & ptp_cfg_pkg::STATUS_FRAME_WMASK[15:8];
			end
		end
	end

	// ------------------------------------------------------------------
	// receive configuration
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_cfg_reg <= ptp_cfg_pkg::CONFIG_RESET;
		end else if (wr_en && pready
			&& is_reg(word_idx, ptp_cfg_pkg::RECEIVE_TIMESTAMP_CONFIG_IDX)) begin
			if (pstrb[0]) begin
				rx_cfg_reg[7:0] <= wdata16[7:0];
			end
			if (pstrb[1]) begin
				rx_cfg_reg[15:8] <= wdata16[15:8];
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			domain_reg <= 8'h00;
		end else if (wr_en && pready && pstrb[0]
			&& is_reg(word_idx, ptp_cfg_pkg::RECEIVE_DOMAIN_CONFIG_IDX)) begin
			domain_reg <= wdata16[7:0];
		end
	end

	// the half select decides which 16 bits a data access reaches
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			custom_ip_reg <= ptp_cfg_pkg::CUSTOM_IP_RESET;
		end else if (wr_en && pready
			&& is_reg(word_idx, ptp_cfg_pkg::CUSTOM_IP_DATA_IDX)) begin
			if (rx_cfg_reg[ptp_cfg_pkg::IP_HALF_B]) begin
				if (pstrb[0]) custom_ip_reg[7:0] <= wdata16[7:0];
				if (pstrb[1]) custom_ip_reg[15:8] <= wdata16[15:8];
			end else begin
				if (pstrb[0]) custom_ip_reg[23:16] <= wdata16[7:0];
				if (pstrb[1]) custom_ip_reg[31:24] <= wdata16[15:8];
			end
		end
	end

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= 32'h0000_0000;
			if (is_reg(word_idx, ptp_cfg_pkg::STATUS_FRAME_CONFIG_IDX)) begin
				prdata[15:0] <= status_cfg_reg & ptp_cfg_pkg::STATUS_FRAME_WMASK;
			end else if (is_reg(word_idx, ptp_cfg_pkg::RECEIVE_TIMESTAMP_CONFIG_IDX)) begin
				prdata[15:0] <= rx_cfg_reg;
			end else if (is_reg(word_idx, ptp_cfg_pkg::RECEIVE_DOMAIN_CONFIG_IDX)) begin
				prdata[7:0] <= domain_reg;
			end else if (is_reg(word_idx, ptp_cfg_pkg::CUSTOM_IP_DATA_IDX)) begin
				prdata[15:0] <= rx_cfg_reg[ptp_cfg_pkg::IP_HALF_B]
					? custom_ip_reg[15:0] : custom_ip_reg[31:16];
			end else if (is_reg(word_idx, ptp_cfg_pkg::MATCH_COUNT_IDX)) begin
				prdata[15:0] <= match_count_reg;
			end
		end
	end

	// ------------------------------------------------------------------
	// receive filter
	// ------------------------------------------------------------------
	rx_stamp_filter u_filter (
		.core_clk       (core_clk),
		.reset_n        (reset_n),
		.rx_cfg         (rx_cfg_reg),
		.domain_value   (domain_reg),
		.custom_ip      (custom_ip_reg),
		.msg_valid      (msg_valid),
		.msg_encap      (msg_encap),
		.msg_version    (msg_version),
		.msg_domain     (msg_domain),
		.msg_alt_master (msg_alt_master),
		.msg_control    (msg_control),
		.msg_dest_ip    (msg_dest_ip),
		.stamp_pulse    (stamp_int),
		.reject_pulse   (reject_int)
	);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_stamp_pulse  <= 1'b0;
			rx_reject_pulse <= 1'b0;
		end else begin
			rx_stamp_pulse  <= stamp_int;
			rx_reject_pulse <= reject_int;
		end
	end

	// saturating count of stamped messages, visible to software
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			match_count_reg <= 16'h0000;
		end else if (stamp_int && match_count_reg != 16'hFFFF) begin
			match_count_reg <= match_count_reg + 16'h0001;
		end
	end

	// ------------------------------------------------------------------
	// status frame builder controls
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_source_addr <= 48'h0000_0000_0000;
		end else begin
			unique case (src_sel)
				2'h0: frame_source_addr <= VENDOR_ADDR_A;
				2'h1: frame_source_addr <= VENDOR_ADDR_B;
				2'h2: frame_source_addr <= MULTICAST_DEST;
				2'h3: frame_source_addr <= 48'h0000_0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			min_preamble         <= 3'h0;
			status_byte_order    <= 1'b0;
			status_frame_ip_type <= 1'b0;
		end else begin
			min_preamble         <= status_cfg_reg[ptp_cfg_pkg::MIN_PRE_LSB +: 3];
			status_byte_order    <= status_cfg_reg[ptp_cfg_pkg::BYTE_ORDER_B];
			status_frame_ip_type <= status_cfg_reg[ptp_cfg_pkg::IP_TYPE_B];
		end
	end

	// content bits: 5 readback, 4 error, 3 tx, 2 rx, 1 trigger, 0 event
	assign content_now = {
		readback_ready && status_cfg_reg[ptp_cfg_pkg::READBACK_B],
		error_ready    && status_cfg_reg[ptp_cfg_pkg::ERR_DELIV_B],
		tx_stamp_ready && status_cfg_reg[ptp_cfg_pkg::TX_STAMP_B],
		rx_stamp_ready && status_cfg_reg[ptp_cfg_pkg::RX_STAMP_B],
		trigger_ready  && status_cfg_reg[ptp_cfg_pkg::TRIGGER_B],
		event_ready    && status_cfg_reg[ptp_cfg_pkg::EVENT_B]
	};

	// errors ride along but never start a frame by themselves
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_request <= 1'b0;
			frame_content <= 6'h00;
		end else begin
			frame_request <= content_now[5] || (|content_now[3:0]);
			frame_content <= (content_now[5] || (|content_now[3:0]))
				? content_now : 6'h00;
		end
	end

endmodule

// >>> design/rx_stamp_filter.sv
// receive event message filter: decides whether a parsed message is stamped
// assumes parsed header fields arrive with a one-cycle msg_valid strobe
`timescale 1ns/100ps
module rx_stamp_filter (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	// configuration
	input  wire logic [15:0]           rx_cfg,
	input  wire logic [7:0]            domain_value,
	input  wire logic [31:0]           custom_ip,
	// parsed message
	input  wire logic                  msg_valid,
	input  wire ptp_cfg_pkg::encap_e   msg_encap,
	input  wire logic [3:0]            msg_version,
	input  wire logic [7:0]            msg_domain,
	input  wire logic                  msg_alt_master,
	input  wire logic [7:0]            msg_control,
	input  wire logic [31:0]           msg_dest_ip,
	// decision
	output logic                       stamp_pulse,
	output logic                       reject_pulse
);

	logic encap_ok;
	logic version_ok;
	logic domain_ok;
	logic addr_ok;
	logic alt_ok;
	logic slave_ok;
	logic std_hit;
	logic [2:0] std_en;
	logic [3:0] ver_cfg;

	assign std_en  = rx_cfg[ptp_cfg_pkg::STD_IP_LSB +: 3];
	assign ver_cfg = rx_cfg[ptp_cfg_pkg::VERSION_LSB +: 4];

	always_comb begin
		unique case (msg_encap)
			ptp_cfg_pkg::ENCAP_LAYER2: encap_ok = rx_cfg[ptp_cfg_pkg::LAYER2_B];
			ptp_cfg_pkg::ENCAP_V6:     encap_ok = rx_cfg[ptp_cfg_pkg::V6_B];
			ptp_cfg_pkg::ENCAP_V4:     encap_ok = rx_cfg[ptp_cfg_pkg::V4_B];
			default:                   encap_ok = 1'b0;
		endcase
	end

	// zero turns the version check off
	assign version_ok = (ver_cfg == 4'h0) || (ver_cfg == msg_version);
	assign domain_ok  = !rx_cfg[ptp_cfg_pkg::DOMAIN_EN_B]
		|| (msg_domain == domain_value);
	assign alt_ok     = !(rx_cfg[ptp_cfg_pkg::ALT_SKIP_B] && msg_alt_master);
	assign slave_ok   = !rx_cfg[ptp_cfg_pkg::SLAVE_ONLY_B]
		|| (msg_control != ptp_cfg_pkg::SLAVE_SKIP_CTRL);

	// the ipv4 destination of a v6 message is the low word of its address
	assign std_hit = (std_en[0] && msg_dest_ip == ptp_cfg_pkg::STD_ADDR_A)
		|| (std_en[1] && msg_dest_ip >= ptp_cfg_pkg::STD_ADDR_B_LO
			&& msg_dest_ip <= ptp_cfg_pkg::STD_ADDR_B_HI)
		|| (std_en[2] && msg_dest_ip == ptp_cfg_pkg::STD_ADDR_C);

	// layer2 carries no ip address; with no address filter on, any passes
	always_comb begin
		if (msg_encap == ptp_cfg_pkg::ENCAP_LAYER2) begin
			addr_ok = 1'b1;
		end else if (std_en == 3'h0 && !rx_cfg[ptp_cfg_pkg::CUSTOM_IP_B]) begin
			addr_ok = 1'b1;
		end else begin
			addr_ok = std_hit
				|| (rx_cfg[ptp_cfg_pkg::CUSTOM_IP_B] && msg_dest_ip == custom_ip);
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stamp_pulse  <= 1'b0;
			reject_pulse <= 1'b0;
		end else begin
			stamp_pulse  <= msg_valid && rx_cfg[ptp_cfg_pkg::CAPTURE_B] && encap_ok
				&& version_ok && domain_ok && addr_ok && alt_ok && slave_ok;
			reject_pulse <= msg_valid && !(rx_cfg[ptp_cfg_pkg::CAPTURE_B] && encap_ok
				&& version_ok && domain_ok && addr_ok && alt_ok && slave_ok);
		end
	end

endmodule

// >>> verification/msg_feeder.sv
// partner model: parser delivering message fields and pending status content
// assumes its tasks are called right after a rising clock edge
`timescale 1ns/100ps
module msg_feeder (
	// clock
	input  wire logic           core_clk,
	// parsed message
	output logic                msg_valid,
	output ptp_cfg_pkg::encap_e msg_encap,
	output logic [3:0]          msg_version,
	output logic [7:0]          msg_domain,
	output logic                msg_alt_master,
	output logic [7:0]          msg_control,
	output logic [31:0]         msg_dest_ip,
	// pending content levels
	output logic [5:0]          ready_lvl
);
	logic [1:0]  enc_reg;
	logic [54:0] fields;
	assign msg_encap = ptp_cfg_pkg::encap_e'(enc_reg);
	assign {enc_reg, msg_version, msg_domain, msg_alt_master, msg_control,
		msg_dest_ip} = fields;
	initial begin
		msg_valid = 1'h0;
		fields = 55'h0;
		ready_lvl = 6'h0;
	end
	// invert fields after the strobe so stale values cannot pass
	task automatic send(input logic [54:0] f);
		msg_valid <= 1'h1;
		fields <= f;
		@(posedge core_clk);
		msg_valid <= 1'h0;
		fields <= ~f;
	endtask
	task automatic set_ready(input logic [5:0] r);
		ready_lvl <= r;
	endtask
endmodule

// >>> verification/ptp_rx_filter_status_frame_props.sv
// checker for the status frame and receive stamp filter block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/100ps
module ptp_rx_filter_status_frame_props (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        reset_n,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// message side
	input wire logic        msg_valid,
	input wire logic        rx_stamp_pulse,
	input wire logic        rx_reject_pulse,
	// status frame side
	input wire logic        tx_stamp_ready,
	input wire logic        readback_ready,
	input wire logic [47:0] frame_source_addr,
	input wire logic [2:0]  min_preamble,
	input wire logic        status_byte_order,
	input wire logic        status_frame_ip_type,
	input wire logic        frame_request,
	input wire logic [5:0]  frame_content
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic wr_access;
	logic mapped;
	assign wr_access = psel && penable && pwrite && pready;
	assign mapped = paddr inside {12'h060, 12'h064, 12'h06C, 12'h070, 12'h080};
	sequence s_setup; psel && !penable; endsequence
	sequence s_answer; pready ##1 !pready; endsequence
	sequence s_decided; rx_stamp_pulse != rx_reject_pulse; endsequence
	property p_apb_answer; s_setup |=> s_answer; endproperty
	property p_slverr; pready |-> pslverr == !mapped; endproperty
	property p_status_top; pready && !pwrite && paddr == 12'h060 |-> prdata[31:13] == 19'h0; endproperty
	property p_msg_answer; msg_valid |-> ##2 s_decided; endproperty
	property p_no_stray; rx_stamp_pulse || rx_reject_pulse |-> $past(msg_valid, 2); endproperty
	property p_request; frame_request == (frame_content[5] || |frame_content[3:0]); endproperty
	property p_tx_content; frame_content[3] |-> $past(tx_stamp_ready); endproperty
	property p_rb_content; frame_content[5] |-> $past(readback_ready); endproperty
	// the load of the default source address after reset comes with no write
	property p_cfg_by_write; $past(reset_n, 2) && $changed({frame_source_addr, min_preamble,
		status_byte_order, status_frame_ip_type}) |-> $past(wr_access) || $past(wr_access, 2);
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer not one cycle");
	a_slverr: assert property (p_slverr) else $error("error response wrong for address");
	a_status_top: assert property (p_status_top) else $error("status top bits not zero");
	a_msg_answer: assert property (p_msg_answer) else $error("no single decision");
	a_no_stray: assert property (p_no_stray) else $error("decision without message");
	a_request: assert property (p_request) else $error("frame request mismatch");
	a_tx_content: assert property (p_tx_content) else $error("tx content unprompted");
	a_rb_content: assert property (p_rb_content) else $error("readback unprompted");
	a_cfg_by_write: assert property (p_cfg_by_write) else $error("config moved alone");
endmodule

bind ptp_rx_filter_status_frame ptp_rx_filter_status_frame_props i_props (
	.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
	.msg_valid, .rx_stamp_pulse, .rx_reject_pulse, .tx_stamp_ready, .readback_ready,
	.frame_source_addr, .min_preamble, .status_byte_order, .status_frame_ip_type,
	.frame_request, .frame_content
);

// >>> verification/test_ptp_rx_filter_status_frame.sv
// self-checking bench for the status frame and receive stamp filter block
// assumes the checker is bound in and the feeder stands for the parser side
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
	begin check_count++; if ((got) !== (ex)) begin num_errors++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module test_ptp_rx_filter_status_frame;
	localparam logic [47:0] ADDR_A = 48'h02_AA_00_00_00_01; // arbitrary value
	localparam logic [47:0] ADDR_B = 48'h02_BB_00_00_00_02; // arbitrary value
	localparam logic [47:0] MCAST  = 48'h01_00_5E_00_00_81;
	localparam logic [11:0] SF  = {2'h0, ptp_cfg_pkg::STATUS_FRAME_CONFIG_IDX, 2'h0};
	localparam logic [11:0] RX  = {2'h0, ptp_cfg_pkg::RECEIVE_TIMESTAMP_CONFIG_IDX, 2'h0};
	localparam logic [11:0] IPD = {2'h0, ptp_cfg_pkg::CUSTOM_IP_DATA_IDX, 2'h0};
	localparam logic [11:0] DOM = {2'h0, ptp_cfg_pkg::RECEIVE_DOMAIN_CONFIG_IDX, 2'h0};
	localparam logic [11:0] CNT = {2'h0, ptp_cfg_pkg::MATCH_COUNT_IDX, 2'h0};
	localparam logic [1:0]  L2 = ptp_cfg_pkg::ENCAP_LAYER2;
	localparam logic [1:0]  V4 = ptp_cfg_pkg::ENCAP_V4;
	localparam logic [1:0]  V6 = ptp_cfg_pkg::ENCAP_V6;
	localparam logic [31:0] BIP = 32'h0A00_0001;
	localparam logic [20:0] NOM = {4'h2, 8'h00, 1'h0, 8'h00}; // version, domain, alt, control
	logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, msg_valid, msg_alt_master, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, msg_dest_ip, r;
	logic [3:0]  pstrb, msg_version;
	logic [7:0]  msg_domain, msg_control;
	logic [5:0]  ready_lvl, frame_content;
	logic [47:0] frame_source_addr;
	logic [2:0]  min_preamble;
	logic status_byte_order, status_frame_ip_type, frame_request, rx_stamp_pulse, rx_reject_pulse;
	ptp_cfg_pkg::encap_e msg_encap;
	int num_errors, check_count, cycles, stamps;

	ptp_rx_filter_status_frame #(.VENDOR_ADDR_A(ADDR_A), .VENDOR_ADDR_B(ADDR_B),
		.MULTICAST_DEST(MCAST)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.msg_valid(msg_valid), .msg_encap(msg_encap), .msg_version(msg_version),
		.msg_domain(msg_domain), .msg_alt_master(msg_alt_master), .msg_control(msg_control),
		.msg_dest_ip(msg_dest_ip), .tx_stamp_ready(ready_lvl[3]), .rx_stamp_ready(ready_lvl[2]),
		.trigger_ready(ready_lvl[1]), .event_ready(ready_lvl[0]),
		.readback_ready(ready_lvl[5]), .error_ready(ready_lvl[4]),
		.frame_source_addr(frame_source_addr), .min_preamble(min_preamble),
		.status_byte_order(status_byte_order), .status_frame_ip_type(status_frame_ip_type),
		.frame_request(frame_request), .frame_content(frame_content),
		.rx_stamp_pulse(rx_stamp_pulse), .rx_reject_pulse(rx_reject_pulse));
	msg_feeder i_feed (.core_clk(core_clk), .msg_valid(msg_valid), .msg_encap(msg_encap),
		.msg_version(msg_version), .msg_domain(msg_domain), .msg_alt_master(msg_alt_master),
		.msg_control(msg_control), .msg_dest_ip(msg_dest_ip), .ready_lvl(ready_lvl));

	initial begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// one apb transfer after a gap cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n == 50) num_errors++;
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic settle;
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		apb(1'h0, SF, 32'h0, r, e);
		`CHK("status cfg", 32'h0, r)
		apb(1'h0, RX, 32'h0, r, e);
		`CHK("rx cfg", 32'h0, r)
		apb(1'h0, DOM, 32'h0, r, e);
		`CHK("domain", 32'h0, r)
		`CHK("source addr", ADDR_A, frame_source_addr)
		`CHK("request", 1'h0, frame_request)
		apb(1'h0, 12'h0F0, 32'h0, r, e);
		`CHK("unmapped error", 1'h1, e)
		$display("reset values done");
	endtask
	task automatic t_status;
		logic [47:0] src_tab [0:3];
		src_tab = '{ADDR_A, ADDR_B, MCAST, 48'h0};
		apb(1'h1, SF, 32'hFFFF_FFFF, r, e);
		apb(1'h0, SF, 32'h0, r, e);
		`CHK("status readback", 32'h0000_1FFF, r)
		settle();
		`CHK("byte order", 1'h1, status_byte_order)
		`CHK("ip type", 1'h1, status_frame_ip_type)
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, SF, (32'(i) << 11) | (32'(i) << 8), r, e);
			settle();
			`CHK("source addr", src_tab[i], frame_source_addr)
			`CHK("preamble", 3'(i), min_preamble)
			`CHK("byte order", 1'h0, status_byte_order)
			`CHK("ip type", 1'h0, status_frame_ip_type)
		end
		$display("status config done");
	endtask
	task automatic t_delivery;
		i_feed.set_ready(6'h3F);
		apb(1'h1, SF, 32'h10, r, e);
		settle();
		`CHK("error only request", 1'h0, frame_request)
		for (int b = 0; b < 6; b++) begin
			if (b == 4) continue;
			apb(1'h1, SF, 32'h10 | (32'h1 << b), r, e);
			settle();
			`CHK("content", 6'h10 | (6'h1 << b), frame_content)
			`CHK("request", 1'h1, frame_request)
		end
		apb(1'h1, SF, 32'h1F, r, e);
		i_feed.set_ready(6'h37);
		settle();
		`CHK("content", 6'h17, frame_content)
		$display("delivery done");
	endtask
	task automatic t_custom_ip;
		apb(1'h1, RX, 32'h0, r, e);
		apb(1'h1, IPD, 32'h0000_C0A8, r, e);
		apb(1'h1, RX, 32'h2000, r, e);
		apb(1'h1, IPD, 32'h0000_0001, r, e);
		apb(1'h0, IPD, 32'h0, r, e);
		`CHK("ip low half", 32'h0000_0001, r)
		apb(1'h1, RX, 32'h0, r, e);
		apb(1'h0, IPD, 32'h0, r, e);
		`CHK("ip high half", 32'h0000_C0A8, r)
		$display("custom address done");
	endtask
	task automatic run(input logic [15:0] cfg, input logic [1:0] enc, input logic [20:0] hdr,
			input logic [31:0] ip, input logic ex);
		apb(1'h1, RX, {16'h0, cfg}, r, e);
		@(posedge core_clk);
		i_feed.send({enc, hdr, ip});
		@(posedge core_clk);
		#1;
		`CHK("stamp", ex, rx_stamp_pulse)
		`CHK("reject", ~ex, rx_reject_pulse)
		stamps += int'(ex);
	endtask
	task automatic t_filter;
		apb(1'h1, DOM, 32'h2A, r, e);
		run(16'h0024, V4, NOM, BIP, 1'h0);
		run(16'h0025, V4, NOM, BIP, 1'h1);
		run(16'h0025, V6, NOM, BIP, 1'h0);
		run(16'h0045, V6, NOM, BIP, 1'h1);
		run(16'h0085, L2, NOM, BIP, 1'h1);
		run(16'h00E5, 2'h3, NOM, BIP, 1'h0);
		run(16'h0025, V4, {4'h3, 8'h00, 1'h0, 8'h00}, BIP, 1'h0);
		run(16'h0021, V4, {4'hF, 8'h00, 1'h0, 8'h00}, BIP, 1'h1);
		run(16'h8025, V4, {4'h2, 8'h2A, 1'h0, 8'h00}, BIP, 1'h1);
		run(16'h8025, V4, {4'h2, 8'h2B, 1'h0, 8'h00}, BIP, 1'h0);
		run(16'h0025, V4, {4'h2, 8'h2B, 1'h0, 8'h00}, BIP, 1'h1);
		run(16'h4025, V4, {4'h2, 8'h00, 1'h1, 8'h00}, BIP, 1'h0);
		run(16'h0025, V4, {4'h2, 8'h00, 1'h1, 8'h00}, BIP, 1'h1);
		run(16'h0825, V4, {4'h2, 8'h00, 1'h0, 8'h01}, BIP, 1'h0);
		run(16'h0825, V4, {4'h2, 8'h00, 1'h0, 8'h02}, BIP, 1'h1);
		run(16'h0125, V4, NOM, ptp_cfg_pkg::STD_ADDR_A, 1'h1);
		run(16'h0125, V4, NOM, ptp_cfg_pkg::STD_ADDR_B_LO, 1'h0);
		run(16'h0225, V4, NOM, ptp_cfg_pkg::STD_ADDR_B_HI, 1'h1);
		run(16'h0425, V4, NOM, ptp_cfg_pkg::STD_ADDR_C, 1'h1);
		run(16'h1025, V4, NOM, 32'hC0A8_0001, 1'h1);
		run(16'h1025, V4, NOM, 32'hC0A8_0002, 1'h0);
		apb(1'h0, CNT, 32'h0, r, e);
		`CHK("stamp count", 32'(stamps), r)
		$display("filter done");
	endtask

	initial begin
		reset_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'h1;
		t_reset();
		t_status();
		t_delivery();
		t_custom_ip();
		t_filter();
		end_sim();
	end
endmodule
